// [ldsp_serial_port.v]
`include "ldsp_map.vh"

module ldsp_serial_port (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_sclk,
  input wire i_sdi,
  input wire i_latch,
  output reg o_serial_out_pin,
  output reg o_cmd_valid,
  output reg [7:0] o_cmd_addr,
  output reg [7:0] o_cmd_data,
  output reg [11:0] o_channel_disable_bits
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [1:0] sclk_s_r, sdi_s_r, lat_s_r;
  reg sclk_d_r, lat_d_r;

  // Two stages per pin before use
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_s_r <= 2'h0;
      sdi_s_r <= 2'h0;
      lat_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
      lat_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], i_sclk};
      sdi_s_r <= {sdi_s_r[0], i_sdi};
      lat_s_r <= {lat_s_r[0], i_latch};
      sclk_d_r <= sclk_s_r[1];
      lat_d_r <= lat_s_r[1];
    end
  end

  wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
  wire lat_rise = lat_s_r[1] & ~lat_d_r;

  // ****************************************
  // Frame decode helpers
  // ****************************************

  // Address field of a collected frame, shifted in first so it sits high
  function [7:0] frame_addr;
    input [15:0] frame;
    begin
      frame_addr = frame[`LDSP_ADDR_MSB:`LDSP_ADDR_LSB];
    end
  endfunction

  // Data field of a collected frame, shifted in last so it sits low
  function [7:0] frame_data;
    input [15:0] frame;
    begin
      frame_data = frame[`LDSP_DATA_MSB:`LDSP_DATA_LSB];
    end
  endfunction

  // True when a frame carries the given address code
  function addr_is;
    input [15:0] frame;
    input [7:0] code;
    begin
      addr_is = (frame_addr(frame) == code);
    end
  endfunction

  // ****************************************
  // Frame state
  // ****************************************

  // Shift register, bit counter and broken-frame flag
  reg [15:0] shift_r;
  reg [15:0] shift_nxt;
  reg [`LDSP_CNT_W-1:0] cnt_r;
  reg [`LDSP_CNT_W-1:0] cnt_nxt;
  reg len_bad_r;
  reg len_bad_nxt;

  // Channel-disable halves, one per write address
  reg [5:0] dis_lo_r;
  reg [5:0] dis_lo_nxt;
  reg [5:0] dis_hi_r;
  reg [5:0] dis_hi_nxt;

  // Next values of the registered outputs
  reg cmd_valid_nxt;
  reg [7:0] cmd_addr_nxt;
  reg [7:0] cmd_data_nxt;
  reg sdo_nxt;
  reg [11:0] chdis_nxt;

  // Length is judged modulo a frame so a chain of frames still counts
  wire frame_ok = (cnt_r == `LDSP_CNT_FULL) && !len_bad_r;

  // A frame is acted on only at the latch edge
  wire cmd_take = lat_rise && frame_ok;

  // A valid read of the disable bits reloads the shift register
  wire read_hit = cmd_take && addr_is(shift_r, `LDSP_ADDR_DIS_READ);

  // ****************************************
  // Shift register next value
  // ****************************************

  // Latch has priority: a read loads the answer, otherwise the frame stays
  always @* begin
    shift_nxt = shift_r;
    if (read_hit)
      shift_nxt = {`LDSP_READ_PAD, dis_lo_r};
    else if (!lat_rise && sclk_rise)
      shift_nxt = {shift_r[14:0], sdi_s_r[1]};
  end

  // ****************************************
  // Bit counter next value
  // ****************************************

  // Counts 1 to 16 and wraps, so cascaded frames keep 16-bit units
  always @* begin
    cnt_nxt = cnt_r;
    if (lat_rise)
      cnt_nxt = `LDSP_CNT_ZERO;
    else if (sclk_rise && cnt_r == `LDSP_CNT_FULL)
      cnt_nxt = `LDSP_CNT_ONE;
    else if (sclk_rise)
      cnt_nxt = cnt_r + `LDSP_CNT_ONE;
  end

  // ****************************************
  // Broken frame detection
  // ****************************************

  // A clock edge while the latch is high breaks the frame being built
  always @* begin
    len_bad_nxt = len_bad_r;
    if (lat_rise)
      len_bad_nxt = 1'b0;
    else if (sclk_rise && lat_s_r[1])
      len_bad_nxt = 1'b1;
  end

  // ****************************************
  // Register writes
  // ****************************************

  // Only a whole frame at the latch edge may change the disable bits
  always @* begin
    dis_lo_nxt = dis_lo_r;
    dis_hi_nxt = dis_hi_r;
    if (cmd_take && addr_is(shift_r, `LDSP_ADDR_DIS_WR0))
      dis_lo_nxt = shift_r[`LDSP_DIS_W-1:0];
    if (cmd_take && addr_is(shift_r, `LDSP_ADDR_DIS_WR1))
      dis_hi_nxt = shift_r[`LDSP_DIS_W-1:0];
  end

  // ****************************************
  // Command report
  // ****************************************

  // One-cycle pulse with the frame that was taken; fields hold after it
  always @* begin
    cmd_valid_nxt = cmd_take;
    cmd_addr_nxt = o_cmd_addr;
    cmd_data_nxt = o_cmd_data;
    if (cmd_take) begin
      cmd_addr_nxt = frame_addr(shift_r);
      cmd_data_nxt = frame_data(shift_r);
    end
  end

  // ****************************************
  // Serial output
  // ****************************************

  // At the latch the pin shows the word about to go out, so a read
  // presents its first answer bit before the host's first clock edge
  always @* begin
    sdo_nxt = o_serial_out_pin;
    if (lat_rise)
      sdo_nxt = shift_nxt[15];
    else if (sclk_fall)
      sdo_nxt = shift_r[15];
  end

  // Channel state seen by the output stage
  always @* begin
    chdis_nxt = {dis_hi_r, dis_lo_r};
  end

  // ****************************************
  // Frame registers
  // ****************************************

  // Shift register, counter and flag
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_r <= `LDSP_SHIFT_RESET;
      cnt_r <= `LDSP_CNT_ZERO;
      len_bad_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      len_bad_r <= len_bad_nxt;
    end
  end

  // ****************************************
  // Disable bit registers
  // ****************************************

  // All channels start deactivated
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dis_lo_r <= `LDSP_DIS_RESET;
      dis_hi_r <= `LDSP_DIS_RESET;
    end else begin
      dis_lo_r <= dis_lo_nxt;
      dis_hi_r <= dis_hi_nxt;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************

  // Every output comes straight from a flip-flop
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_valid <= 1'b0;
      o_cmd_addr <= 8'h00;
      o_cmd_data <= 8'h00;
      o_serial_out_pin <= 1'b0;
      o_channel_disable_bits <= `LDSP_CHDIS_RESET;
    end else begin
      o_cmd_valid <= cmd_valid_nxt;
      o_cmd_addr <= cmd_addr_nxt;
      o_cmd_data <= cmd_data_nxt;
      o_serial_out_pin <= sdo_nxt;
      o_channel_disable_bits <= chdis_nxt;
    end
  end

endmodule

// [ldsp_map.vh]
`ifndef LDSP_MAP_VH
`define LDSP_MAP_VH
`define LDSP_FRAME_BITS 16
`define LDSP_CNT_W 5
`define LDSP_ADDR_DIS_READ 8'h92
`define LDSP_ADDR_DIS_WR0 8'h52
`define LDSP_ADDR_DIS_WR1 8'h53
`define LDSP_DIS_RESET 6'h3F
`define LDSP_DIS_W 6
`define LDSP_CNT_ZERO 5'h00
`define LDSP_CNT_ONE 5'h01
`define LDSP_CNT_FULL 5'h10
`define LDSP_ADDR_MSB 15
`define LDSP_ADDR_LSB 8
`define LDSP_DATA_MSB 7
`define LDSP_DATA_LSB 0
`define LDSP_SHIFT_RESET 16'h0000
`define LDSP_READ_PAD 10'h000
`define LDSP_CHDIS_RESET 12'hFFF
`endif

// [ldsp_serial_port_asserts.sv]
module ldsp_serial_port_asserts(input wire logic i_core_clk, i_rst_n, i_sclk, i_latch,
  o_serial_out_pin, o_cmd_valid, input wire logic [7:0] o_cmd_addr, o_cmd_data,
  input wire logic [11:0] o_channel_disable_bits);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_vld_pulse: assert property (o_cmd_valid |=> !o_cmd_valid) else $error("pulse");
  a_vld_latch: assert property (o_cmd_valid |-> i_latch) else $error("latch");
  a_cmd_hold: assert property (!o_cmd_valid |-> $stable({o_cmd_addr, o_cmd_data}))
    else $error("cmd");
  a_dis_cause: assert property ($changed(o_channel_disable_bits) |-> $past(o_cmd_valid))
    else $error("dis");
  a_dis_low: assert property (o_cmd_valid && o_cmd_addr == 8'h52 |=>
    o_channel_disable_bits[5:0] == o_cmd_data[5:0]) else $error("low");
  a_dis_high: assert property (o_cmd_valid && o_cmd_addr == 8'h53 |=>
    o_channel_disable_bits[11:6] == o_cmd_data[5:0]) else $error("high");
  a_read_msb: assert property (o_cmd_valid && o_cmd_addr == 8'h92 |=> !o_serial_out_pin)
    else $error("read");
  a_sdo_edge: assert property ($changed(o_serial_out_pin) |->
    !$past(i_sclk) || $past(i_latch)) else $error("sdo");
endmodule
bind ldsp_serial_port ldsp_serial_port_asserts chk_u(.*);

// [ldsp_host_model.sv]
module ldsp_host_model(input wire logic i_core_clk, o_serial_out_pin,
  output logic i_sclk = 1'b0, i_sdi = 1'b0, i_latch = 1'b0);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rx;
  // Shifts n bits MSB first on an 80 ns sclk, then strobes the shared latch
  task automatic send(logic [15:0] f, int n, logic lat);
    for (int i = n - 1; i >= 0; i--) begin
      i_sdi <= f[i];
      repeat (4) @(posedge i_core_clk);
      i_sclk <= 1'b1;
      rx <= {rx[14:0], o_serial_out_pin};
      repeat (4) @(posedge i_core_clk);
      i_sclk <= 1'b0;
    end
    i_sdi <= ~i_sdi;
    repeat (5) @(posedge i_core_clk);
    i_latch <= lat;
    repeat (8) @(posedge i_core_clk);
    i_latch <= 1'b0;
    repeat (8) @(posedge i_core_clk);
  endtask
endmodule

// [ldsp_serial_port_bench.sv]
module ldsp_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_sclk, i_sdi, i_latch, o_serial_out_pin, o_cmd_valid;
  logic [7:0] o_cmd_addr, o_cmd_data;
  logic [11:0] o_channel_disable_bits;
  wire [15:0] cmd = {o_cmd_addr, o_cmd_data}, dis = {4'h0, o_channel_disable_bits};
  int fail_count = 0, checks_done = 0, vld_seen = 0;
  // Counts command pulses so the valid output is judged too
  always @(posedge i_core_clk) if (o_cmd_valid) vld_seen <= vld_seen + 1;
  always #5 i_core_clk = ~i_core_clk;
  ldsp_serial_port dut_u(.*);
  ldsp_host_model host_u(.*);
  task chk(string s, logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", s, e, g); end
  endtask
  task tally_and_finish;
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A write, then a 15-bit frame that must leave everything alone
  task t_write;
    host_u.send(16'h5215, 16, 1'b1);
    chk("cmd", 16'h5215, cmd);
    host_u.send(16'h5300, 15, 1'b1);
    chk("short", 16'h5215, cmd);
    chk("valid", 16'h0001, vld_seen[15:0]);
    $display("write done");
  endtask
  // Read back channels 0 to 5, then a two-frame chain with one latch
  task t_read_chain;
    host_u.send(16'h532A, 16, 1'b1);
    host_u.send(16'h9200, 16, 1'b1);
    host_u.send(16'h0000, 16, 1'b1);
    chk("read", 16'h0015, host_u.rx);
    chk("dis", 16'h0A95, dis);
    host_u.send(16'h5201, 16, 1'b0);
    host_u.send(16'h5233, 16, 1'b1);
    chk("pass", 16'h5201, host_u.rx);
    chk("chain", 16'h0AB3, dis);
    $display("read chain done");
  endtask
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    chk("rst", 16'h0FFF, dis);
    repeat (4) @(posedge i_core_clk);
    t_write();
    t_read_chain();
    tally_and_finish();
  end
endmodule
